// *** pkg/ifoc_params.svh ***
// Constants for the interlaced field output control block
`ifndef IFOC_PARAMS_SVH
`define IFOC_PARAMS_SVH

// Pixel and sensor geometry
`define IFOC_PIX_W 8
`define IFOC_OUT_W 9
`define IFOC_ROWS 8
`define IFOC_ROW_W 3
`define IFOC_LAST_ROW 3'h7
`define IFOC_COLS 4
`define IFOC_COL_W 2
`define IFOC_LAST_COL 2'h3
`define IFOC_HALF_ROWS 4
`define IFOC_PROW_W 2
`define IFOC_LAST_PROW 2'h3
`define IFOC_MEM_DEPTH 16
`define IFOC_MEM_AW 4

// Output buffer
`define IFOC_BUF_CNT_W 2
`define IFOC_BUF_FULL 2'h2

// Field timing
`define IFOC_FRAME_RATE_HZ 30
`define IFOC_FIELDS_PER_FRAME 2
`define IFOC_CLK_PERIOD_NS 10
`define IFOC_FIELD_PERIOD_NS (1000000000 / (`IFOC_FIELDS_PER_FRAME * `IFOC_FRAME_RATE_HZ))
`define IFOC_FIELD_GAP_CYC (`IFOC_FIELD_PERIOD_NS / `IFOC_CLK_PERIOD_NS)
`define IFOC_GAP_W 21

`endif

// *** pkg/ifoc_pkg.sv ***
// Types for the interlaced field output control block
`include "ifoc_params.svh"

package ifoc_pkg;

	typedef enum logic [1:0] {
		first_field_only,
		second_field_only,
		fields_appended,
		fields_interleaved
	} ifoc_field_readout_select_t;

	typedef enum logic [1:0] {
		st_idle,
		st_live,
		st_wait,
		st_play
	} ifoc_phase_t;

	typedef struct packed {
		logic [`IFOC_OUT_W-1:0] data;
		logic first;
		logic last;
	} ifoc_word_t;

	typedef struct packed {
		ifoc_phase_t st;
		ifoc_field_readout_select_t mode;
		logic field;
		logic [`IFOC_ROW_W-1:0] row;
		logic [`IFOC_COL_W-1:0] col;
		logic [`IFOC_PROW_W-1:0] prow;
		logic [`IFOC_COL_W-1:0] pcol;
		logic [`IFOC_GAP_W-1:0] gap;
		logic fresh;
		logic played;
		logic [`IFOC_BUF_CNT_W-1:0] cnt;
		ifoc_word_t e0;
		ifoc_word_t e1;
		logic out_valid;
		logic sens_ready;
		logic sens_start;
		logic busy;
	} ifoc_state_t;

endpackage : ifoc_pkg

// *** hdl/ifoc_top.sv ***
// Field acquisition sequencing, row binning, field memory and frame output
//
// Summary of operation
// - Four field output selections, one mode input.
// - First-field mode: trigger gives field 0 frame.
// - Single-field frames have half the sensor rows.
// - Second-field mode: trigger gives field 1 frame.
// - Field 0 bins rows 0+1, 2+3, ...
// - Field 1 bins rows 1+2, 3+4, ...
// - Appended: field 0 to memory, field 1 auto.
// - Appended frame: field 0 rows then field 1.
// - Interleaved: buffer field 0, merge with field 1.
// - Two-field modes need only one trigger.
// - Each field gets full exposure time.
// - Field 1 starts one field period later.
`timescale 1ns/100ps
`include "ifoc_params.svh"

module ifoc_top #(
	parameter int unsigned FIELD_GAP_CYC = `IFOC_FIELD_GAP_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic frame_trigger,
	input wire logic [1:0] field_readout_select,
	output logic sens_start,
	output logic sens_field,
	input wire logic sens_valid,
	input wire logic [`IFOC_PIX_W-1:0] sens_data,
	output logic sens_ready,
	output logic out_valid,
	input wire logic out_ready,
	output logic [`IFOC_OUT_W-1:0] out_data,
	output logic out_first,
	output logic out_last,
	output logic busy
);

	////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [`IFOC_MEM_AW-1:0] mem_addr(
		input logic [`IFOC_PROW_W-1:0] r,
		input logic [`IFOC_COL_W-1:0] c
	);
		return {r, c};
	endfunction : mem_addr

	function automatic logic is_two(input ifoc_pkg::ifoc_field_readout_select_t m);
		return (m == ifoc_pkg::fields_appended) || (m == ifoc_pkg::fields_interleaved);
	endfunction : is_two

	// Row that closes a binned pair; the last field 1 row stands alone
	function automatic logic emits_row(
		input logic f,
		input logic [`IFOC_ROW_W-1:0] r
	);
		if (f) begin
			return (r != '0) && (!r[0] || (r == `IFOC_LAST_ROW));
		end
		return r[0];
	endfunction : emits_row

	function automatic logic need_play(input ifoc_pkg::ifoc_state_t x);
		return (x.st == ifoc_pkg::st_live) && (x.mode == ifoc_pkg::fields_interleaved)
			&& x.field && (x.col == '0) && emits_row(x.field, x.row) && !x.played;
	endfunction : need_play

	////////////////////////////////////////////////////////////////////////
	// State and storage

	ifoc_pkg::ifoc_state_t s;
	ifoc_pkg::ifoc_state_t next_s;
	ifoc_pkg::ifoc_word_t pw;

	// Line buffer holds the first row of each pair
	logic [`IFOC_PIX_W-1:0] line_mem [`IFOC_COLS];
	// Field memory holds binned field 0 in two-field modes
	logic [`IFOC_OUT_W-1:0] fld_mem [`IFOC_MEM_DEPTH];

	logic push;
	logic pop;
	logic room;
	logic line_we;
	logic mem_we;
	logic [`IFOC_MEM_AW-1:0] mem_wa;
	logic [`IFOC_OUT_W-1:0] sum;

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_s = s;
		next_s.sens_start = 1'b0;
		push = 1'b0;
		pw = '0;
		line_we = 1'b0;
		mem_we = 1'b0;
		mem_wa = '0;
		sum = `IFOC_OUT_W'({1'b0, line_mem[s.col]} + {1'b0, sens_data});
		pop = s.out_valid && out_ready;
		room = (s.cnt != `IFOC_BUF_FULL) || pop;

		if (s.gap != '0) begin
			next_s.gap = s.gap - `IFOC_GAP_W'(1);
		end

		case (s.st)
			ifoc_pkg::st_idle: begin
				// Only idle takes a trigger
				if (frame_trigger) begin
					next_s.mode = ifoc_pkg::ifoc_field_readout_select_t'(field_readout_select);
					next_s.field = (field_readout_select == ifoc_pkg::second_field_only);
					next_s.sens_start = 1'b1;
					next_s.row = '0;
					next_s.col = '0;
					next_s.prow = '0;
					next_s.fresh = 1'b1;
					next_s.played = 1'b0;
					next_s.gap = `IFOC_GAP_W'(FIELD_GAP_CYC - 1);
					next_s.st = ifoc_pkg::st_live;
				end
			end
			ifoc_pkg::st_live: begin
				if (need_play(s)) begin
					next_s.pcol = '0;
					next_s.st = ifoc_pkg::st_play;
				end else if (sens_valid && s.sens_ready) begin
					if (s.field && (s.row == '0)) begin
						// Row 0 has no partner in field 1
						next_s.fresh = s.fresh;
					end else if (!emits_row(s.field, s.row)) begin
						line_we = 1'b1;
					end else if (!s.field && is_two(s.mode)) begin
						mem_we = 1'b1;
						mem_wa = mem_addr(s.row[`IFOC_ROW_W-1:1], s.col);
					end else begin
						push = 1'b1;
						pw.data = (s.field && (s.row == `IFOC_LAST_ROW))
							? {1'b0, sens_data} : sum;
						pw.first = s.fresh;
						pw.last = (s.row == `IFOC_LAST_ROW) && (s.col == `IFOC_LAST_COL);
						next_s.fresh = 1'b0;
					end
					next_s.col = s.col + `IFOC_COL_W'(1);
					if (s.col == `IFOC_LAST_COL) begin
						next_s.col = '0;
						next_s.row = s.row + `IFOC_ROW_W'(1);
						if (emits_row(s.field, s.row)) begin
							next_s.played = 1'b0;
						end
						if (s.row == `IFOC_LAST_ROW) begin
							// Second field follows without a trigger
							next_s.st = (!s.field && is_two(s.mode))
								? ifoc_pkg::st_wait : ifoc_pkg::st_idle;
						end
					end
				end
			end
			ifoc_pkg::st_wait: begin
				// Slow readout only delays field 1, never shortens exposure
				if (s.gap == '0) begin
					next_s.sens_start = 1'b1;
					next_s.field = 1'b1;
					next_s.row = '0;
					next_s.col = '0;
					next_s.prow = '0;
					next_s.pcol = '0;
					next_s.played = 1'b0;
					next_s.st = (s.mode == ifoc_pkg::fields_appended)
						? ifoc_pkg::st_play : ifoc_pkg::st_live;
				end
			end
			ifoc_pkg::st_play: begin
				if (room) begin
					push = 1'b1;
					pw.data = fld_mem[mem_addr(s.prow, s.pcol)];
					pw.first = s.fresh;
					pw.last = 1'b0;
					next_s.fresh = 1'b0;
					next_s.pcol = s.pcol + `IFOC_COL_W'(1);
					if (s.pcol == `IFOC_LAST_COL) begin
						next_s.pcol = '0;
						next_s.prow = s.prow + `IFOC_PROW_W'(1);
						if (s.mode == ifoc_pkg::fields_interleaved) begin
							next_s.played = 1'b1;
							next_s.st = ifoc_pkg::st_live;
						end else if (s.prow == `IFOC_LAST_PROW) begin
							next_s.st = ifoc_pkg::st_live;
						end
					end
				end
			end
			default: begin
				next_s.st = ifoc_pkg::st_idle;
			end
		endcase

		// Two-entry output buffer, head is the output register
		if (pop) begin
			next_s.e0 = s.e1;
			next_s.cnt = s.cnt - `IFOC_BUF_CNT_W'(1);
		end
		if (push) begin
			if (next_s.cnt == '0) begin
				next_s.e0 = pw;
			end else begin
				next_s.e1 = pw;
			end
			next_s.cnt = next_s.cnt + `IFOC_BUF_CNT_W'(1);
		end
		next_s.out_valid = (next_s.cnt != '0);
		// Ready is registered, so it promises room one cycle ahead
		next_s.sens_ready = (next_s.st == ifoc_pkg::st_live)
			&& (next_s.cnt != `IFOC_BUF_FULL) && !need_play(next_s);
		next_s.busy = (next_s.st != ifoc_pkg::st_idle);
	end

	////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// Storage carries no reset; contents are always written before read
	always_ff @(posedge clk_sys) begin
		if (line_we) begin
			line_mem[s.col] <= sens_data;
		end
		if (mem_we) begin
			fld_mem[mem_wa] <= sum;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign sens_start = s.sens_start;
	assign sens_field = s.field;
	assign sens_ready = s.sens_ready;
	assign out_valid = s.out_valid;
	assign out_data = s.e0.data;
	assign out_first = s.e0.first;
	assign out_last = s.e0.last;
	assign busy = s.busy;

endmodule : ifoc_top

// *** dv/ifoc_properties.sv ***
// Port checks for the field output control block
`timescale 1ns/100ps
`include "ifoc_params.svh"
module ifoc_properties #(
	parameter int unsigned FIELD_GAP_CYC = 50
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic frame_trigger,
	input wire logic [1:0] field_readout_select,
	input wire logic sens_start,
	input wire logic sens_field,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic [`IFOC_OUT_W-1:0] out_data,
	input wire logic busy
);
	// Cycles since the last field start
	int unsigned since;
	logic two;
	always_ff @(posedge clk_sys) begin
		since <= (rst || sens_start) ? 1 : since + 1;
		two <= rst ? 1'b0 : (frame_trigger && !busy) ? field_readout_select[1] : two;
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	start_pulse_a: assert property (sens_start |=> !sens_start)
		else $error("start too long");
	trig_start_a: assert property (frame_trigger && !busy |=> sens_start && busy)
		else $error("trigger lost");
	first_field_a: assert property (
		frame_trigger && !busy |=> sens_field == ($past(field_readout_select) == 2'h1))
		else $error("wrong field");
	second_start_a: assert property (
		frame_trigger && !busy && field_readout_select[1] |=> ##[1:800] sens_start && sens_field)
		else $error("no second field");
	field_gap_a: assert property (sens_start && sens_field && two |-> since >= FIELD_GAP_CYC)
		else $error("field too early");
	retrig_ignore_a: assert property (busy && frame_trigger |=> !sens_start || sens_field)
		else $error("busy trigger taken");
	out_hold_a: assert property (
		out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("word dropped");
	reset_quiet_a: assert property (disable iff (1'b0) rst |=> !busy && !out_valid)
		else $error("active after reset");
endmodule : ifoc_properties

bind ifoc_top ifoc_properties #(.FIELD_GAP_CYC(FIELD_GAP_CYC)) u_props (.*);

// *** dv/ifoc_sensor_model.sv ***
// Sensor readout model: 32 row-major beats per start
`timescale 1ns/100ps
`include "ifoc_params.svh"
module ifoc_sensor_model (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic sens_start,
	input wire logic sens_ready,
	output logic sens_valid,
	output logic [`IFOC_PIX_W-1:0] sens_data
);
	int b = 32;
	logic row_gap = 1'b0;
	initial begin
		sens_valid = 1'b0;
		sens_data = 8'h00;
	end
	always @(posedge clk_sys) begin
		// Idle cycle after every row keeps the sensor slower than the block
		row_gap = sens_valid && sens_ready && (b % 4 == 3);
		if (sens_valid && sens_ready)
			b = b + 1;
		if (sens_start)
			b = 0;
		if (rst)
			b = 32;
		sens_valid <= b < 32 && !row_gap;
		// Toggles when idle so stale data never looks valid
		sens_data <= (b < 32 && !row_gap) ? 8'(b / 4 * 29 + b % 4 * 7 + 1) : ~sens_data;
	end
endmodule : ifoc_sensor_model

// *** dv/interlaced_field_output_control_tb.sv ***
// Self-checking bench for the field output control block
`timescale 1ns/100ps
`include "ifoc_params.svh"
`define CHECK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
	$display("unexpected at %0t: value mismatch", $time); end end
module interlaced_field_output_control_tb;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic frame_trigger = 1'b0;
	logic out_ready = 1'b0;
	logic [1:0] field_readout_select = 2'h0;
	logic sens_start, sens_field, sens_valid, sens_ready, out_valid, out_first, out_last, busy;
	logic [`IFOC_PIX_W-1:0] sens_data;
	logic [`IFOC_OUT_W-1:0] out_data;
	int errors = 0;
	int n_compared = 0;
	int cyc = 0;
	int starts = 0;
	// Mode, words per frame, receiver stall period (0 never stalls)
	int rows [6][3] = '{'{0, 16, 0}, '{1, 16, 3}, '{2, 32, 0}, '{2, 32, 2}, '{3, 32, 0}, '{3, 32, 3}};

	ifoc_top #(.FIELD_GAP_CYC(50)) dut (.*);
	ifoc_sensor_model sensor (.*);

	////////////////////////////////////////////////////////////////
	function automatic logic [8:0] pix(int r, int c);
		return 9'(r * 29 + c * 7 + 1);
	endfunction : pix
	function automatic logic [8:0] bin(int f, int k, int c);
		if (f == 0) return pix(2 * k, c) + pix(2 * k + 1, c);
		if (k == 3) return pix(7, c);
		return pix(2 * k + 1, c) + pix(2 * k + 2, c);
	endfunction : bin
	function automatic logic [8:0] word(int m, int i);
		if (m < 2) return bin(m, i / 4, i % 4);
		if (m == 2) return bin(i / 16, i / 4 % 4, i % 4);
		return bin(i / 4 % 2, i / 8, i % 4);
	endfunction : word

	task automatic run_frame(input logic [1:0] m, input int n, input int stall);
		int got;
		got = 0;
		@(negedge clk_sys);
		starts = 0;
		field_readout_select = m;
		frame_trigger = 1'b1;
		@(negedge clk_sys);
		frame_trigger = 1'b0;
		`CHECK({busy, sens_start, sens_field}, {2'h3, m == 2'h1})
		while (got < n) begin
			@(negedge clk_sys);
			out_ready = stall == 0 || cyc % stall != 0;
			if (out_valid && out_ready) begin
				`CHECK(out_data, word(m, got))
				`CHECK({out_first, out_last}, {got == 0, got == n - 1})
				got++;
			end
		end
		while (busy) @(negedge clk_sys);
		`CHECK(starts, m[1] ? 2 : 1)
	endtask : run_frame

	task complete_run;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : complete_run

	////////////////////////////////////////////////////////////////
	initial forever #5 clk_sys = ~clk_sys;
	always @(negedge clk_sys) begin
		cyc++;
		starts += sens_start;
		if (cyc == 20000) begin
			errors++;
			complete_run();
		end
	end

	initial begin
		repeat (2) @(negedge clk_sys);
		rst = 1'b0;
		foreach (rows[i])
			run_frame(2'(rows[i][0]), rows[i][1], rows[i][2]);
		// Trigger and mode change mid-sequence must leave the frame intact
		fork
			run_frame(2'h3, 32, 0);
			begin
				repeat (20) @(negedge clk_sys);
				frame_trigger = 1'b1;
				field_readout_select = 2'h0;
				@(negedge clk_sys);
				frame_trigger = 1'b0;
			end
		join
		field_readout_select = 2'h2;
		frame_trigger = 1'b1;
		@(negedge clk_sys);
		frame_trigger = 1'b0;
		repeat (30) @(negedge clk_sys);
		rst = 1'b1;
		repeat (2) @(negedge clk_sys);
		`CHECK({busy, out_valid, sens_ready}, 3'h0)
		rst = 1'b0;
		run_frame(2'h1, 16, 2);
		complete_run();
	end
endmodule : interlaced_field_output_control_tb
